// >>> dpsc_regs.vh
// constants for the dual pot serial command decoder
`ifndef DPSC_REGS_VH
`define DPSC_REGS_VH
// ----------------------------------------
// opcodes, upper nibble of instruction byte; status is the whole byte, step the upper 7 bits
// ----------------------------------------
`define DPSC_OP_RD_SLOT     4'hB
`define DPSC_OP_WR_SLOT     4'hC
`define DPSC_OP_STATUS      8'h51
`define DPSC_OP_GRESTORE    4'h1
`define DPSC_OP_GSAVE       4'h8
`define DPSC_OP_SAVE        4'hE
`define DPSC_OP_RESTORE     4'hD
`define DPSC_OP_STEP        7'h10
// ----------------------------------------
// timing, reset and tap limit values
// ----------------------------------------
`define DPSC_NVW_TIME_MS    5
`define DPSC_CLK_MHZ        200
`define DPSC_NVW_CYC        (`DPSC_NVW_TIME_MS * 1000 * `DPSC_CLK_MHZ)
`define DPSC_WIPER_RST      6'h00
`define DPSC_TAP_MAX        6'h3F
`endif

// >>> dpsc_decoder.v
// serial instruction decoder for a dual 64-tap pot
//
// Function
// - slot read: opcode 1011, slot, zero, pot; device shifts out slot byte
// - slot write: opcode 1100, slot, zero, pot, then data byte stored
// - status read 01010001 returns busy flag in bit 0, bits 7..6 zero
// - global restore 0001 slot 00 loads slot of every pot into wipers
// - global save 1000 slot 00 copies every wiper into slot, then writes
// - single save 1110 copies one wiper into slot, then nonvolatile write
// - single restore 1101 loads selected slot into that pot's wiper
// - step 0010000 pot, then direction bits until chip select rises
// - programming cycle starts only when chip select returns high
// - busy flag is one while a nonvolatile write is in progress
// - input high steps wiper up, low steps it down, one tap per pulse
// - programming completes within 5 ms of its start
`timescale 1ns/1ps
`include "dpsc_regs.vh"
`default_nettype none

module dpsc_decoder #(
	parameter [5:0]  TYPE_CODE = 6'h2A,   // arbitrary device type code
	parameter        NVW_CYC   = `DPSC_NVW_CYC
) (
	input  wire        clk_i,
	input  wire        nrst_i,
	input  wire        sck_i,
	input  wire        cs_n_i,
	input  wire        sdi_i,
	input  wire        address_pin_high_i,
	input  wire        address_pin_low_i,
	output reg         sdo_o,
	output reg         sdo_oe_n_o,
	output reg  [5:0]  wiper0_o,
	output reg  [5:0]  wiper1_o,
	output reg         write_busy_flag_o
);
	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	reg [1:0] sck_s_r, cs_s_r, sdi_s_r, ap_s_r;
	reg       sck_d_r;
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sck_s_r <= 2'h0;
			cs_s_r  <= 2'h3;
			sdi_s_r <= 2'h0;
			ap_s_r  <= 2'h0;
			sck_d_r <= 1'b0;
		end else begin
			sck_s_r <= {sck_s_r[0], sck_i};
			cs_s_r  <= {cs_s_r[0], cs_n_i};
			sdi_s_r <= {sdi_s_r[0], sdi_i};
			ap_s_r  <= {ap_s_r[0], address_pin_high_i};
			sck_d_r <= sck_s_r[1];
		end
	end
	reg [1:0] al_s_r;
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i)
			al_s_r <= 2'h0;
		else
			al_s_r <= {al_s_r[0], address_pin_low_i};
	end
	wire cs_n   = cs_s_r[1];
	wire sck_rise = sck_s_r[1] & ~sck_d_r;
	wire sck_fall = ~sck_s_r[1] & sck_d_r;
	wire sdi    = sdi_s_r[1];

	// ----------------------------------------
	// storage: 8 slots of 6 bits, index {pot, slot}
	// ----------------------------------------
	reg [5:0] slot_r [0:7];
	reg [5:0] nv_dat_r [0:7];
	reg [7:0] nv_mask_r;

	// ----------------------------------------
	// frame state
	// ----------------------------------------
	localparam [4:0] ST_ADDR = 5'b00001, ST_INST = 5'b00010,
	                 ST_DATA = 5'b00100, ST_IDLE = 5'b01000,
	                 ST_SKIP = 5'b10000;
	reg [4:0]  st_r;
	reg [2:0]  bcnt_r;
	reg [7:0]  sh_r;
	reg [7:0]  inst_r;
	reg [7:0]  tx_r;
	reg        cs_d_r;
	reg        pend_r;
	reg [31:0] nvw_cnt_r;
	wire [7:0] byte_nxt = {sh_r[6:0], sdi};
	wire       pot = inst_r[0];
	wire [1:0] sel = inst_r[3:2];
	wire [7:0] addr_ok = {TYPE_CODE, ap_s_r[1], al_s_r[1]};
	integer k;

	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_r <= ST_ADDR;
			bcnt_r <= 3'h0;
			sh_r <= 8'h00;
			inst_r <= 8'h00;
			tx_r <= 8'h00;
			cs_d_r <= 1'b1;
			pend_r <= 1'b0;
			nvw_cnt_r <= 32'h0;
			nv_mask_r <= 8'h00;
			sdo_o <= 1'b0;
			sdo_oe_n_o <= 1'b1;
			wiper0_o <= `DPSC_WIPER_RST;
			wiper1_o <= `DPSC_WIPER_RST;
			write_busy_flag_o <= 1'b0;
			for (k = 0; k < 8; k = k + 1) begin
				slot_r[k] <= `DPSC_WIPER_RST;
				nv_dat_r[k] <= `DPSC_WIPER_RST;
			end
		end else begin
			cs_d_r <= cs_n;
			// programming timer
			if (nvw_cnt_r != 32'h0) begin
				nvw_cnt_r <= nvw_cnt_r - 32'h1;
				if (nvw_cnt_r == 32'h1) begin
					write_busy_flag_o <= 1'b0;
					for (k = 0; k < 8; k = k + 1)
						if (nv_mask_r[k])
							slot_r[k] <= nv_dat_r[k];
					nv_mask_r <= 8'h00;
				end
			end
			if (cs_n) begin
				st_r <= ST_ADDR;
				bcnt_r <= 3'h0;
				sdo_oe_n_o <= 1'b1;
				if (!cs_d_r && pend_r && !write_busy_flag_o) begin
					pend_r <= 1'b0;
					write_busy_flag_o <= 1'b1;
					nvw_cnt_r <= NVW_CYC[31:0];
				end else if (!cs_d_r) begin
					pend_r <= 1'b0;
					nv_mask_r <= write_busy_flag_o ? nv_mask_r : 8'h00;
				end
			end else if (sck_rise) begin
				sh_r <= byte_nxt;
				bcnt_r <= bcnt_r + 3'h1;
				if (st_r == ST_IDLE && inst_r[7:1] == `DPSC_OP_STEP) begin
					if (pot) begin
						if (sdi && wiper1_o != `DPSC_TAP_MAX)
							wiper1_o <= wiper1_o + 6'h1;
						else if (!sdi && wiper1_o != 6'h00)
							wiper1_o <= wiper1_o - 6'h1;
					end else begin
						if (sdi && wiper0_o != `DPSC_TAP_MAX)
							wiper0_o <= wiper0_o + 6'h1;
						else if (!sdi && wiper0_o != 6'h00)
							wiper0_o <= wiper0_o - 6'h1;
					end
				end else if (bcnt_r == 3'h7) begin
					case (st_r)
					ST_ADDR: begin
						if (byte_nxt == addr_ok)
							st_r <= ST_INST;
						else
							st_r <= ST_SKIP;
					end
					ST_INST: begin
						inst_r <= byte_nxt;
						st_r <= ST_IDLE;
						if (byte_nxt == `DPSC_OP_STATUS) begin
							tx_r <= {7'h00, write_busy_flag_o};
							st_r <= ST_DATA;
						end else if (byte_nxt[7:4] == `DPSC_OP_RD_SLOT && !byte_nxt[1]) begin
							tx_r <= {2'b00, slot_r[{byte_nxt[0], byte_nxt[3:2]}]};
							st_r <= ST_DATA;
						end else if (byte_nxt[7:4] == `DPSC_OP_WR_SLOT && !byte_nxt[1]) begin
							st_r <= ST_DATA;
						end else if (byte_nxt[7:4] == `DPSC_OP_RESTORE && !byte_nxt[1]) begin
							if (byte_nxt[0])
								wiper1_o <= slot_r[{1'b1, byte_nxt[3:2]}];
							else
								wiper0_o <= slot_r[{1'b0, byte_nxt[3:2]}];
						end else if (byte_nxt[7:4] == `DPSC_OP_GRESTORE && byte_nxt[1:0] == 2'b00) begin
							wiper0_o <= slot_r[{1'b0, byte_nxt[3:2]}];
							wiper1_o <= slot_r[{1'b1, byte_nxt[3:2]}];
						end else if (!write_busy_flag_o && byte_nxt[7:4] == `DPSC_OP_SAVE
							&& !byte_nxt[1]) begin
							nv_mask_r[{byte_nxt[0], byte_nxt[3:2]}] <= 1'b1;
							nv_dat_r[{byte_nxt[0], byte_nxt[3:2]}] <=
								byte_nxt[0] ? wiper1_o : wiper0_o;
							pend_r <= 1'b1;
						end else if (!write_busy_flag_o && byte_nxt[7:4] == `DPSC_OP_GSAVE
							&& byte_nxt[1:0] == 2'b00) begin
							nv_mask_r[{1'b0, byte_nxt[3:2]}] <= 1'b1;
							nv_mask_r[{1'b1, byte_nxt[3:2]}] <= 1'b1;
							nv_dat_r[{1'b0, byte_nxt[3:2]}] <= wiper0_o;
							nv_dat_r[{1'b1, byte_nxt[3:2]}] <= wiper1_o;
							pend_r <= 1'b1;
						end
					end
					ST_DATA: begin
						st_r <= ST_SKIP;
						if (inst_r[7:4] == `DPSC_OP_WR_SLOT && !write_busy_flag_o) begin
							nv_mask_r[{pot, sel}] <= 1'b1;
							nv_dat_r[{pot, sel}] <= byte_nxt[5:0];
							pend_r <= 1'b1;
						end
					end
					default: st_r <= ST_SKIP;
					endcase
				end
			end else if (sck_fall) begin
				// shift data out on the falling edge for modes 0 and 3
				if (st_r == ST_DATA && inst_r[7:4] != `DPSC_OP_WR_SLOT) begin
					sdo_oe_n_o <= 1'b0;
					sdo_o <= tx_r[3'h7 - bcnt_r];
				end else begin
					sdo_oe_n_o <= 1'b1;
				end
			end
		end
	end
endmodule // dpsc_decoder

`default_nettype wire

// >>> dpsc_decoder_assertions.sv
// port checker for the pot command decoder
`timescale 1ns/1ps
`default_nettype none
module dpsc_decoder_assertions #(parameter NVW_CYC = 400) (
	input wire logic       clk_i,
	input wire logic       nrst_i,
	input wire logic       sck_i,
	input wire logic       cs_n_i,
	input wire logic       sdi_i,
	input wire logic       address_pin_high_i,
	input wire logic       address_pin_low_i,
	input wire logic       sdo_o,
	input wire logic       sdo_oe_n_o,
	input wire logic [5:0] wiper0_o,
	input wire logic [5:0] wiper1_o,
	input wire logic       write_busy_flag_o
);
	int cnt_r;
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) cnt_r <= 0;
		else cnt_r <= write_busy_flag_o ? cnt_r + 1 : 0;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	chk_oe_idle: assert property ($rose(cs_n_i) |-> ##[0:4] sdo_oe_n_o)
		else $error("serial output still enabled after frame");
	chk_sdo_edge: assert property (!sdo_oe_n_o && $changed(sdo_o) |-> !sck_i)
		else $error("read data moved while serial clock high");
	chk_busy_start: assert property ($rose(write_busy_flag_o) |-> cs_n_i && !$past(cs_n_i, 8))
		else $error("busy rose away from a frame end");
	chk_busy_len: assert property ($fell(write_busy_flag_o) |-> cnt_r inside {[NVW_CYC-1:NVW_CYC+1]})
		else $error("busy length wrong");
	chk_busy_max: assert property (cnt_r <= NVW_CYC + 1)
		else $error("programming overran its limit");
	chk_sat_pot0: assert property (wiper0_o inside {6'h00, 6'h3F} |=> wiper0_o != ~$past(wiper0_o))
		else $error("wiper 0 wrapped");
	chk_sat_pot1: assert property (wiper1_o inside {6'h00, 6'h3F} |=> wiper1_o != ~$past(wiper1_o))
		else $error("wiper 1 wrapped");
	chk_wiper_quiet: assert property (cs_n_i [*8] |-> $stable(wiper0_o) && $stable(wiper1_o))
		else $error("wiper moved outside a frame");
	cover property ($rose(write_busy_flag_o));
	cover property (wiper1_o == 6'h3F);
	cover property (!sdo_oe_n_o);
endmodule // dpsc_decoder_assertions
bind dpsc_decoder dpsc_decoder_assertions #(.NVW_CYC(NVW_CYC)) chk_u (.*);
`default_nettype wire

// >>> dpsc_host_model.sv
// serial host model, mode 0, 64 ns clock
`timescale 1ns/1ps
`default_nettype none
module dpsc_host_model (
	output var logic sck_o,
	output var logic cs_n_o,
	output var logic sdi_o,
	input wire logic sdo_i,
	input wire logic sdo_oe_n_i
);
	logic sdo_seen = 1'b0;
	initial begin
		sck_o = 1'b0;
		cs_n_o = 1'b1;
		sdi_o = 1'b0;
	end
	// a released output reads inverted, and any driven bit is remembered in sdo_seen
	task automatic xfer(input logic [31:0] tx, input int n, output logic [7:0] rx);
		sdo_seen = 1'b0;
		rx = 8'h00;
		cs_n_o <= 1'b0;
		for (int i = 0; i < n; i++) begin
			sdi_o <= tx[31-i];
			#32 sck_o <= 1'b1;
			rx = {rx[6:0], sdo_oe_n_i ? ~sdo_i : sdo_i};
			sdo_seen = sdo_seen | ~sdo_oe_n_i;
			#32 sck_o <= 1'b0;
		end
		#32 cs_n_o <= 1'b1;
		sdi_o <= ~sdi_o;
		#600;
	endtask
endmodule // dpsc_host_model
`default_nettype wire

// >>> dpsc_decoder_tb_top.sv
// self-checking bench for the pot command decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin failures++; $display("[ERR] %0t %h %h", $time, a, b); end end
module dpsc_decoder_tb_top;
	localparam logic [7:0] AD = {6'h2A, 2'b10};
	logic       clk_i, nrst_i, sdo_o, sdo_oe_n_o, busy, sck, cs_n, sdi;
	logic [5:0] w0, w1;
	logic       aph = 1'b1, apl = 1'b0;
	logic [7:0] rx, st;
	int         failures = 0, compares = 0, k;
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	dpsc_decoder #(.NVW_CYC(400)) dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .sck_i(sck),
		.cs_n_i(cs_n), .sdi_i(sdi), .address_pin_high_i(aph), .address_pin_low_i(apl),
		.sdo_o(sdo_o), .sdo_oe_n_o(sdo_oe_n_o), .wiper0_o(w0), .wiper1_o(w1),
		.write_busy_flag_o(busy));
	dpsc_host_model host_u (.sck_o(sck), .cs_n_o(cs_n), .sdi_o(sdi), .sdo_i(sdo_o),
		.sdo_oe_n_i(sdo_oe_n_o));
	function automatic logic [7:0] sv(int i);
		return {2'b00, 6'(197 + 31 * i)};
	endfunction
	task automatic final_report();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic cmd(input logic [7:0] ad, ins, input logic [15:0] dat, input int n);
		host_u.xfer({ad, ins, dat}, n, rx);
	endtask
	// program frame, then poll status until the busy flag clears
	task automatic prog(input logic [7:0] ins, dat, input int n);
		cmd(AD, ins, {dat, 8'h00}, n);
		`CHK(busy, 1'b1)
		st = 8'h01;
		for (k = 0; k < 10 && st !== 8'h00; k++) begin
			cmd(AD, 8'h51, 16'h0, 24);
			st = rx;
			if (k == 0) `CHK(st, 8'h01)
		end
		`CHK(st, 8'h00)
		if (k == 10) final_report();
	endtask
	initial begin
		nrst_i = 1'b0;
		repeat (20) @(posedge clk_i);
		nrst_i <= 1'b1;
		repeat (5) @(posedge clk_i);
		#1;
		for (int i = 0; i < 8; i++) prog({4'hC, i[1:0], 1'b0, i[2]}, 8'(197 + 31 * i), 24);
		for (int i = 0; i < 8; i++) begin
			cmd(AD, {4'hB, i[1:0], 1'b0, i[2]}, 16'h0, 24);
			`CHK(rx, sv(i))
		end
		$display("slot write and read done");
		cmd(AD, 8'h10, 16'h0, 16);
		`CHK({w0, w1}, {6'h05, 6'h01})
		cmd(AD ^ 8'h01, 8'hD4, 16'h0, 16);
		`CHK(w0, 6'h05)
		cmd(AD ^ 8'h02, 8'hB0, 16'h0, 24);
		`CHK(host_u.sdo_seen, 1'b0)
		@(posedge clk_i);
		{aph, apl} <= 2'b01;
		cmd(AD ^ 8'h03, 8'hD4, 16'h0, 16);
		`CHK(w0, 6'h24)
		@(posedge clk_i);
		{aph, apl} <= 2'b10;
		cmd(AD, 8'hD8, 16'h0, 16);
		cmd(AD, 8'hD9, 16'h0, 16);
		`CHK({w0, w1}, {6'h03, 6'h3F})
		$display("restore done");
		cmd(AD, 8'h21, 16'hFFFF, 32);
		`CHK(w1, 6'h3F)
		cmd(AD, 8'h21, 16'h0000, 32);
		`CHK(w1, 6'h2F)
		cmd(AD, 8'h20, 16'h0000, 32);
		`CHK(w0, 6'h00)
		cmd(AD, 8'h20, 16'hFFF0, 32);
		`CHK(w0, 6'h08)
		$display("stepping done");
		prog(8'h8C, 8'h00, 16);
		cmd(AD, 8'hBC, 16'h0, 24);
		`CHK(rx, 8'h08)
		cmd(AD, 8'hBD, 16'h0, 24);
		`CHK(rx, 8'h2F)
		prog(8'hE1, 8'h00, 16);
		cmd(AD, 8'hB1, 16'h0, 24);
		`CHK(rx, 8'h2F)
		$display("save done");
		final_report();
	end
endmodule // dpsc_decoder_tb_top
`default_nettype wire
